// ### hw/sfr_flags.sv
// Function
// [R1] The less-than flag pulses for one cycle when a word or double-word compare or window compare finds its operand smaller.
// [R2] The auxiliary timer contact sets when the running timer reaches zero and clears when its trigger goes low.
// [R3] The tool-port error flag rises on every communication error seen at the tool port.
// [R4] With constant scan enabled, a scan longer than the configured period raises the constant-scan error flag.
// [R5] The scan-pulse relay toggles at every scan boundary.
// [R6] The first-scan-high relay is on only in the first scan after run starts and off afterwards.
// [R7] The first-scan-low relay is off only in the first scan after run starts and on afterwards; the code turns it on for one cycle as run starts.
// [R8] The step initial pulse relay is on only during the first scan of a step process after it opens.
// [R9] Clock relays with full periods of 0.01 s, 0.02 s and 0.1 s run freely.
// [R10] Clock relays with full periods of 0.2 s, 1 s and 2 s run freely.
// [R11] A clock relay with a full period of one minute runs freely.
// [R12] All clock relays share one time base with equal halves, and constant-on and constant-off flags exist.
//
// Register access over APB and the placing of the registers are this design's own decisions.
module sfr_flags
    import sfr_pkg::*;
#(
    parameter int TickCyc = sfr_pkg::TICK_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic paddr_unused_dummy,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scanEnd,
    input wire logic cmpValid,
    input wire logic cmpLess,
    input wire logic auxTimerRun,
    input wire logic auxTimerZero,
    input wire logic auxTimerTrig,
    input wire logic toolPortErr,
    input wire logic stepOpen,
    output logic [31:0] flags,
    output logic irq
);
    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    logic [1:0] toolSync_r;
    logic toolPrev_r;
    logic toolRise;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            toolSync_r <= 2'b00;
            toolPrev_r <= 1'b0;
        end else begin
            toolSync_r <= {toolSync_r[0], toolPortErr};
            toolPrev_r <= toolSync_r[1];
        end
    end
    assign toolRise = toolSync_r[1] & ~toolPrev_r;

    // -----------------------------------------------------------------
    // Clock pulse relays
    // -----------------------------------------------------------------
    logic tick;
    logic [NUM_CLK-1:0] waves;

    sfr_timebase #(
        .TickCyc(TickCyc)
    ) u_tb (
        .clk(clk),
        .rst_b(rst_b),
        .tick(tick)
    );

    // Odd tick counts cannot be halved exactly; all defaults are even.
    for (genvar i = 0; i < NUM_CLK; i++) begin : g_clk
        sfr_square #(
            .HalfTicks(CLK_PERIOD_MS[i] / 2)
        ) u_sq (
            .clk(clk),
            .rst_b(rst_b),
            .tick(tick),
            .wave(waves[i])
        ); // [R9] [R10] [R11] [R12]
    end

    // -----------------------------------------------------------------
    // Scan and event state
    // -----------------------------------------------------------------
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] period_r, period_nxt;
    logic [NUM_EVT-1:0] status_r, status_nxt;
    logic [NUM_EVT-1:0] mask_r, mask_nxt;
    logic [31:0] scanCnt_r, scanCnt_nxt;
    logic scanErrHeld_r, scanErrHeld_nxt;
    logic runPrev_r, runPrev_nxt;
    logic firstScan_r, firstScan_nxt;
    logic stepPend_r, stepPend_nxt;
    logic stepInit_r, stepInit_nxt;
    logic scanPulse_r, scanPulse_nxt;
    logic less_r, less_nxt;
    logic auxT_r, auxT_nxt;
    logic toolErr_r, toolErr_nxt;
    logic scanErr_r, scanErr_nxt;
    logic wrEn, rdEn, runStart, scanLate;
    logic [NUM_EVT-1:0] evt;

    always_comb begin
        wrEn = psel & penable & pwrite;
        rdEn = psel & penable & ~pwrite;
        runStart = ctrl_r[CTRL_RUN] & ~runPrev_r;
        runPrev_nxt = ctrl_r[CTRL_RUN];
        ctrl_nxt = ctrl_r;
        period_nxt = period_r;
        mask_nxt = mask_r;

        less_nxt = cmpValid & cmpLess; // [R1]

        auxT_nxt = auxT_r;
        if (!auxTimerTrig) begin
            auxT_nxt = 1'b0; // [R2]
        end else if (auxTimerRun && auxTimerZero) begin
            auxT_nxt = 1'b1; // [R2]
        end

        toolErr_nxt = toolRise; // [R3]

        scanCnt_nxt = scanEnd ? 32'h0000_0000 : scanCnt_r + 32'h0000_0001;
        scanLate = ctrl_r[CTRL_CONST] && (period_r != 32'h0000_0000) && (scanCnt_r == period_r);
        scanErrHeld_nxt = scanEnd ? 1'b0 : (scanErrHeld_r | scanLate);
        scanErr_nxt = scanLate & ~scanErrHeld_r; // [R4]

        scanPulse_nxt = scanEnd ? ~scanPulse_r : scanPulse_r; // [R5]

        firstScan_nxt = firstScan_r;
        if (runStart) begin
            firstScan_nxt = 1'b1; // [R6] [R7]
        end else if (scanEnd) begin
            firstScan_nxt = 1'b0; // [R6] [R7]
        end

        // A step process opened mid-scan takes effect from the next scan.
        stepPend_nxt = stepPend_r;
        stepInit_nxt = stepInit_r;
        if (stepOpen) begin
            stepPend_nxt = 1'b1;
        end
        if (scanEnd) begin
            stepInit_nxt = stepPend_r | stepOpen; // [R8]
            stepPend_nxt = 1'b0;
        end

        evt = '0;
        evt[ST_LESS] = less_nxt;
        evt[ST_AUXT] = auxT_nxt & ~auxT_r;
        evt[ST_TOOLERR] = toolErr_nxt;
        evt[ST_SCANERR] = scanErr_nxt;

        // Set beats clear so an event in the clearing cycle is kept.
        status_nxt = status_r;
        if (wrEn && paddr == ADDR_STATUS) begin
            status_nxt = status_r & ~pwdata[NUM_EVT-1:0];
        end
        status_nxt = status_nxt | evt;

        if (wrEn && paddr == ADDR_MASK) begin
            mask_nxt = pwdata[NUM_EVT-1:0];
        end
        if (wrEn && paddr == ADDR_CTRL) begin
            ctrl_nxt = pwdata;
        end
        if (wrEn && paddr == ADDR_PERIOD) begin
            period_nxt = pwdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= 32'h0000_0000;
            period_r <= PERIOD_RST;
            status_r <= '0;
            mask_r <= '0;
            scanCnt_r <= 32'h0000_0000;
            scanErrHeld_r <= 1'b0;
            runPrev_r <= 1'b0;
            firstScan_r <= 1'b0;
            stepPend_r <= 1'b0;
            stepInit_r <= 1'b0;
            scanPulse_r <= 1'b0;
            less_r <= 1'b0;
            auxT_r <= 1'b0;
            toolErr_r <= 1'b0;
            scanErr_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            period_r <= period_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            scanCnt_r <= scanCnt_nxt;
            scanErrHeld_r <= scanErrHeld_nxt;
            runPrev_r <= runPrev_nxt;
            firstScan_r <= firstScan_nxt;
            stepPend_r <= stepPend_nxt;
            stepInit_r <= stepInit_nxt;
            scanPulse_r <= scanPulse_nxt;
            less_r <= less_nxt;
            auxT_r <= auxT_nxt;
            toolErr_r <= toolErr_nxt;
            scanErr_r <= scanErr_nxt;
        end
    end

    // -----------------------------------------------------------------
    // Flag word, interrupt and bus read
    // -----------------------------------------------------------------
    logic [31:0] flags_nxt, prdata_nxt;
    logic irq_nxt, pready_nxt, pslverr_nxt;

    always_comb begin
        flags_nxt = 32'h0000_0000;
        flags_nxt[BIT_LESS] = less_r;
        flags_nxt[BIT_AUXT] = auxT_r;
        flags_nxt[BIT_TOOLERR] = toolErr_r;
        flags_nxt[BIT_SCANERR] = scanErr_r;
        flags_nxt[BIT_ON] = 1'b1; // [R12]
        flags_nxt[BIT_OFF] = 1'b0; // [R12]
        flags_nxt[BIT_SCANPULSE] = scanPulse_r;
        flags_nxt[BIT_FIRSTHI] = firstScan_r & ctrl_r[CTRL_RUN]; // [R6]
        flags_nxt[BIT_FIRSTLO] = ~firstScan_r & ctrl_r[CTRL_RUN]; // [R7]
        flags_nxt[BIT_STEPINIT] = stepInit_r; // [R8]
        flags_nxt[BIT_CLK0 +: NUM_CLK] = waves;
        irq_nxt = |(status_nxt & mask_nxt);
        // Every access completes in its first access cycle.
        pready_nxt = psel & ~penable;
        pslverr_nxt = 1'b0;
        prdata_nxt = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                ADDR_FLAGS: prdata_nxt = flags;
                ADDR_STATUS: prdata_nxt = 32'(status_r);
                ADDR_MASK: prdata_nxt = 32'(mask_r);
                ADDR_CTRL: prdata_nxt = ctrl_r;
                ADDR_PERIOD: prdata_nxt = period_r;
                default: pslverr_nxt = 1'b1;
            endcase
        end else if (psel && !penable) begin
            unique case (paddr)
                ADDR_FLAGS, ADDR_STATUS, ADDR_MASK, ADDR_CTRL, ADDR_PERIOD: pslverr_nxt = 1'b0;
                default: pslverr_nxt = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= 32'h0000_0000;
            irq <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            flags <= flags_nxt;
            irq <= irq_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end
endmodule // sfr_flags

// ### hw/sfr_pkg.sv
package sfr_pkg;
    // -----------------------------------------------------------------
    // Bus register map (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_PERIOD = 8'h10;
    // -----------------------------------------------------------------
    // Flag word bit positions (relay index within the flag word)
    // -----------------------------------------------------------------
    localparam int BIT_LESS = 12;
    localparam int BIT_AUXT = 13;
    localparam int BIT_TOOLERR = 14;
    localparam int BIT_SCANERR = 15;
    localparam int BIT_ON = 16;
    localparam int BIT_OFF = 17;
    localparam int BIT_SCANPULSE = 18;
    localparam int BIT_FIRSTHI = 19;
    localparam int BIT_FIRSTLO = 20;
    localparam int BIT_STEPINIT = 21;
    localparam int BIT_CLK0 = 24;
    localparam int NUM_CLK = 7;
    // Status (sticky event) bits.
    localparam int ST_LESS = 0;
    localparam int ST_AUXT = 1;
    localparam int ST_TOOLERR = 2;
    localparam int ST_SCANERR = 3;
    localparam int NUM_EVT = 4;
    localparam int CTRL_CONST = 0;
    localparam int CTRL_RUN = 1;
    // -----------------------------------------------------------------
    // Time base
    // -----------------------------------------------------------------
    localparam int CLK_HZ = 200_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
    // Clock relay full periods in 1 ms ticks: 0.01 s .. 1 min.
    localparam int CLK_PERIOD_MS [NUM_CLK] = '{10, 20, 100, 200, 1000, 2000, 60000};
    localparam logic [31:0] PERIOD_RST = 32'h0000_0000;
endpackage : sfr_pkg

// ### hw/sfr_square.sv
module sfr_square #(
    parameter int HalfTicks = 5
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    output logic wave
);
    logic [31:0] cnt_r, cnt_nxt;
    logic wave_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        wave_nxt = wave;
        if (tick) begin
            if (cnt_r == 32'(HalfTicks - 1)) begin
                cnt_nxt = 32'h0000_0000;
                wave_nxt = ~wave;
            end else begin
                cnt_nxt = cnt_r + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 32'h0000_0000;
            wave <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            wave <= wave_nxt;
        end
    end
endmodule // sfr_square

// ### hw/sfr_timebase.sv
module sfr_timebase #(
    parameter int TickCyc = 200000
) (
    input wire logic clk,
    input wire logic rst_b,
    output logic tick
);
    logic [31:0] cnt_r, cnt_nxt;
    logic tick_nxt;

    // Single prescaler shared by every clock relay keeps them phase aligned.
    always_comb begin
        tick_nxt = (cnt_r == 32'(TickCyc - 1));
        cnt_nxt = tick_nxt ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick <= tick_nxt;
        end
    end
endmodule // sfr_timebase

// ### testbench/sfr_flags_chk.sv
// ----------------------------------------
// Port relations of the flag relay block
// ----------------------------------------
module sfr_flags_chk
    import sfr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic scanEnd,
    input wire logic cmpValid,
    input wire logic cmpLess,
    input wire logic [31:0] flags,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_less_set; cmpValid && cmpLess |-> ##2 flags[BIT_LESS]; endproperty
    a_less_set: assert property (p_less_set) else $error("less flag missed");
    property p_less_cause; flags[BIT_LESS] |-> $past(cmpValid && cmpLess, 2); endproperty
    a_less_cause: assert property (p_less_cause) else $error("less flag without cause");
    property p_scan_toggle; scanEnd |-> ##[1:3] $changed(flags[BIT_SCANPULSE]); endproperty
    a_scan_toggle: assert property (p_scan_toggle) else $error("scan pulse did not toggle");
    property p_first_excl; !(flags[BIT_FIRSTHI] && flags[BIT_FIRSTLO]); endproperty
    a_first_excl: assert property (p_first_excl) else $error("both first scan relays on");
    property p_const; $past(rst_b, 3) |-> flags[BIT_ON] && !flags[BIT_OFF]; endproperty
    a_const: assert property (p_const) else $error("constant relays wrong");
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access cycle");
    property p_ready_cause; pready |-> psel && penable; endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready outside access");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    c_less: cover property (flags[BIT_LESS]);
    c_irq: cover property (irq);
    c_err: cover property (pslverr);
endmodule // sfr_flags_chk

// ### testbench/sfr_flags_test.sv
module sfr_flags_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sfr_pkg::*;
    // A short tick keeps the one-minute relay inside the run.
    localparam int TC = 2;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic scanEnd = 1'b0, cmpValid = 1'b0, cmpLess = 1'b0, auxTimerRun = 1'b0, auxTimerZero = 1'b0;
    logic auxTimerTrig = 1'b0, toolPortErr = 1'b0, stepOpen = 1'b0, pready, pslverr, irq, err, old;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, flags, rd;
    logic [NUM_CLK-1:0] prevClk = '0;
    int n_mismatch = 0, tests_run = 0, cyc = 0, rel = 0, hc;
    int nt[NUM_CLK] = '{default: 0};
    int tg[NUM_CLK][4];
    sfr_flags #(.TickCyc(TC)) dut (.clk(clk), .rst_b(rst_b), .paddr_unused_dummy(1'b0), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scanEnd(scanEnd), .cmpValid(cmpValid), .cmpLess(cmpLess), .auxTimerRun(auxTimerRun),
        .auxTimerZero(auxTimerZero), .auxTimerTrig(auxTimerTrig), .toolPortErr(toolPortErr), .stepOpen(stepOpen),
        .flags(flags), .irq(irq));
    initial begin
        forever #2.5 clk = ~clk;
    end
    // ----------------------------------------
    // Clock relay edge log, one cycle stamp for each of the first four edges
    // ----------------------------------------
    always @(posedge clk) begin
        cyc <= cyc + 1;
        prevClk <= flags[BIT_CLK0 +: NUM_CLK];
        for (int i = 0; i < NUM_CLK; i++) begin
            if (rst_b && flags[BIT_CLK0 + i] !== prevClk[i] && nt[i] < 4) begin
                tg[i][nt[i]] = cyc;
                nt[i]++;
            end
        end
    end
    task wrap_up();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(pready, 1'b1);
        if (pready !== 1'b1)
            wrap_up();
    endtask
    // Bits that may pulse for one cycle are polled every edge, never sampled once.
    task waitbit(input int b, input logic v);
        int n;
        n = 0;
        while (flags[b] !== v && n < 16) begin
            @(posedge clk);
            n++;
        end
        chk(flags[b], v);
        if (flags[b] !== v)
            wrap_up();
    endtask
    task scan_end();
        @(posedge clk);
        scanEnd <= 1'b1;
        @(posedge clk);
        scanEnd <= 1'b0;
    endtask
    task t_reset();
        chk(flags[BIT_OFF:BIT_ON], 2'h1);
        apb(1'b1, ADDR_FLAGS, 32'hffffffff);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(rd[BIT_OFF:BIT_ON], 2'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk({err, rd}, 33'h100000000);
        apb(1'b0, ADDR_PERIOD, 32'h0);
        chk(rd, PERIOD_RST);
    endtask
    task t_less();
        @(posedge clk);
        cmpValid <= 1'b1;
        @(posedge clk);
        cmpLess <= 1'b1;
        @(posedge clk);
        cmpValid <= 1'b0;
        cmpLess <= 1'b0;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({irq, rd[ST_LESS]}, 2'h1);
        apb(1'b1, ADDR_MASK, 32'h1);
        // The interrupt is registered at the write edge, so look one edge later.
        @(posedge clk);
        chk(irq, 1'b1);
        apb(1'b1, ADDR_STATUS, 32'h1);
        @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk({irq, rd}, 33'h0);
    endtask
    task t_aux_tool();
        auxTimerRun <= 1'b1;
        auxTimerTrig <= 1'b1;
        repeat (4) @(posedge clk);
        chk(flags[BIT_AUXT], 1'b0);
        auxTimerZero <= 1'b1;
        waitbit(BIT_AUXT, 1'b1);
        auxTimerTrig <= 1'b0;
        auxTimerZero <= 1'b0;
        waitbit(BIT_AUXT, 1'b0);
        toolPortErr <= 1'b1;
        waitbit(BIT_TOOLERR, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[ST_TOOLERR], 1'b1);
        apb(1'b1, ADDR_STATUS, 32'hf);
    endtask
    task t_scan_step();
        apb(1'b1, ADDR_PERIOD, 32'h14);
        apb(1'b1, ADDR_CTRL, 32'h3);
        waitbit(BIT_FIRSTHI, 1'b1);
        chk(flags[BIT_FIRSTLO], 1'b0);
        old = flags[BIT_SCANPULSE];
        scan_end();
        waitbit(BIT_SCANPULSE, !old);
        waitbit(BIT_FIRSTHI, 1'b0);
        stepOpen <= 1'b1;
        @(posedge clk);
        stepOpen <= 1'b0;
        scan_end();
        waitbit(BIT_STEPINIT, 1'b1);
        chk(flags[BIT_FIRSTLO], 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[ST_SCANERR], 1'b0);
        scan_end();
        waitbit(BIT_STEPINIT, 1'b0);
        repeat (30) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[ST_SCANERR], 1'b1);
        chk(flags[BIT_FIRSTHI +: 2], 2'h2);
    endtask
    task t_clocks();
        for (int i = 0; i < NUM_CLK - 1; i++) begin
            hc = CLK_PERIOD_MS[i] / 2 * TC;
            chk(tg[i][2] - tg[i][1], hc);
            chk(tg[i][3] - tg[i][2], hc);
        end
        hc = CLK_PERIOD_MS[NUM_CLK - 1] / 2 * TC;
        chk(nt[NUM_CLK - 1] > 0 && tg[NUM_CLK - 1][0] - rel inside {[hc - 8 : hc + 8]}, 1'b1);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rel = cyc;
        repeat (3) @(posedge clk);
        t_reset();
        t_less();
        t_aux_tool();
        t_scan_step();
        repeat (61000) @(posedge clk);
        t_clocks();
        wrap_up();
    end
endmodule // sfr_flags_test
bind sfr_flags sfr_flags_chk u_chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .scanEnd(scanEnd), .cmpValid(cmpValid), .cmpLess(cmpLess), .flags(flags), .irq(irq));
